// [src/pcm_top.sv]
// Power and clock manager: backup reset stretch, main oscillator start-up,
// bypass, operating modes, master clock selection with prescaler and output.
// Assumes the pins arrive asynchronously and the oscillators are modelled as
// plain level inputs; the slow clock is a tick derived from core_clk.
//
// How it works
// R1: backup reset held for 32768 slow ticks after backup reset pin rises.
// R2: stretched backup reset initialises alarm/wake and shutdown logic state.
// R3: main oscillator enable is clear after reset.
// R4: clearing oscillator enable stops oscillator and clears stable flag.
// R5: writing enable restarts oscillator and loads counter from same write.
// R6: counter decrements every 8 ticks; zero sets stable flag and interrupt.
// R7: bypass bit selects external clock input instead of crystal.
// R8: reset leaves the block in slow clock mode.
// R9: normal mode: power on, core clock on, peripherals as enabled.
// R10: idle stops core clock until interrupt; peripherals keep running.
// R11: slow clock mode turns main oscillator and PLL off.
// R12: standby is slow mode plus stopped core, resumed by interrupt.
// R13: power-down keeps main power off until wake edge or alarm.
// R14: slow clock tick at 32768 Hz drives the manager.
// R15: master clock chosen by selector and prescaler, driven to output pin.
// R16: core clock on after reset, restarted by any enabled interrupt.
// R17: start-up counter runs on the slow clock tick.
`timescale 1ns/100ps
module pcm_top
  import pcm_pkg::*;
#(
  parameter int BACKUP_HOLD = BACKUP_HOLD_SLOW
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire pcm_pkg::pcm_bus_req_t bus_req,
  output logic [31:0]                bus_rdata,
  input  wire logic                  backup_reset_pin,
  input  wire logic                  main_osc_input_pin,
  input  wire logic                  crystal_clk,
  input  wire logic                  wake_pin,
  input  wire logic                  rtc_alarm,
  input  wire logic                  irq_pending,
  output logic                       master_clock_out_pin,
  output logic                       master_clock_out_oe,
  output logic                       master_clock,
  output pcm_pkg::pcm_gate_t         gates,
  output logic                       irq
);
  import pcm_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire  [NSYNC-1:0] raw_in = {irq_pending, rtc_alarm, wake_pin, crystal_clk,
                              main_osc_input_pin, backup_reset_pin};
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end
  wire bk_pin_s  = sync_b[0];
  wire ext_clk_s = sync_b[1];
  wire xtal_s    = sync_b[2];
  wire wake_s    = sync_b[3];
  wire alarm_s   = sync_b[4];
  wire irq_in_s  = sync_b[5];

  // ---------------------------------------------------------------
  // Slow clock tick
  // ---------------------------------------------------------------
  logic [9:0] slow_div;
  wire        slow_tick = (slow_div == SLOW_DIV_LAST);  // see R14
  always_ff @(posedge core_clk) begin
    if (reset) slow_div <= '0;
    else if (slow_tick) slow_div <= '0;
    else slow_div <= slow_div + 10'h001;
  end

  // ---------------------------------------------------------------
  // Backup reset stretch
  // ---------------------------------------------------------------
  logic [16:0] bk_count;
  logic        bk_reset;
  wire         bk_done = (bk_count == 17'(BACKUP_HOLD - 1));
  always_ff @(posedge core_clk) begin
    if (reset || !bk_pin_s) begin
      bk_count <= '0;
      bk_reset <= 1'b1;
    end else if (bk_reset && slow_tick) begin
      if (bk_done) bk_reset <= 1'b0;                   // see R1
      else bk_count <= bk_count + 17'h00001;
    end
  end

  // ---------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------
  wire wr_cg    = bus_req.write && bus_req.addr == ADDR_CLOCK_GEN;
  wire wr_mode  = bus_req.write && bus_req.addr == ADDR_MODE;
  wire wr_per   = bus_req.write && bus_req.addr == ADDR_PERIPH_EN;
  wire wr_stat  = bus_req.write && bus_req.addr == ADDR_STATUS;
  wire wr_mask  = bus_req.write && bus_req.addr == ADDR_INT_MASK;
  wire wr_wake  = bus_req.write && bus_req.addr == ADDR_WAKE_CFG;

  logic                  osc_enable;
  logic                  osc_bypass;
  logic                  clkout_dis;
  logic [1:0]            clk_sel;
  logic [2:0]            prescale;
  logic [7:0]            osc_count_cfg;
  logic [7:0]            osc_counter;
  logic [2:0]            osc_sub;
  logic                  osc_stable;
  logic [NUM_PERIPH-1:0] periph_en;
  logic [NUM_EVENTS-1:0] int_status;
  logic [NUM_EVENTS-1:0] int_mask;
  logic                  wake_rise;
  logic                  alarm_wake_en;
  pcm_mode_t             mode;

  wire [7:0] wr_count = bus_req.wdata[CG_COUNT_LSB +: 8];
  wire       wr_en    = bus_req.wdata[CG_ENABLE_BIT];
  wire [1:0] wr_sel   = bus_req.wdata[CG_SEL_LSB +: 2];
  // Refuse deselecting slow clock while main oscillator is not ready
  wire       sel_ok   = (wr_sel == SEL_SLOW) || (wr_en && osc_stable);
  wire       main_ok  = osc_enable && osc_stable;

  // ---------------------------------------------------------------
  // Clock generator control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_enable    <= 1'b0;                           // see R3
      osc_bypass    <= 1'b0;
      clkout_dis    <= 1'b0;
      clk_sel       <= SEL_SLOW;                       // see R8
      prescale      <= '0;
      osc_count_cfg <= OSC_COUNT_RESET;
    end else if (wr_cg) begin
      osc_enable    <= wr_en;
      osc_bypass    <= bus_req.wdata[CG_BYPASS_BIT];
      clkout_dis    <= bus_req.wdata[CG_CLKOUT_DIS];
      prescale      <= bus_req.wdata[CG_PRE_LSB +: 3];
      osc_count_cfg <= wr_count;
      if (sel_ok) clk_sel <= wr_sel;
    end else if (mode == PCM_SLOW || mode == PCM_STANDBY || mode == PCM_POWER_DOWN) begin
      osc_enable <= 1'b0;                              // see R11
      clk_sel    <= SEL_SLOW;
    end
  end

  // Oscillator start-up counter on slow tick
  wire osc_dec = slow_tick && (osc_sub == OSC_DEC_LAST);   // see R17
  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_counter <= '0;
      osc_sub     <= '0;
      osc_stable  <= 1'b0;
    end else if (wr_cg && wr_en) begin
      osc_counter <= wr_count;                         // see R5
      osc_sub     <= '0;
      osc_stable  <= 1'b0;
    end else if (!osc_enable || (wr_cg && !wr_en)) begin
      osc_stable  <= 1'b0;                             // see R4
    end else if (!osc_stable && slow_tick) begin
      osc_sub <= osc_sub + 3'h1;
      if (osc_dec) begin                               // see R6
        if (osc_counter == 8'h00) osc_stable <= 1'b1;
        else osc_counter <= osc_counter - 8'h01;
      end
    end
  end

  logic osc_stable_d;
  always_ff @(posedge core_clk) begin
    if (reset) osc_stable_d <= 1'b0;
    else osc_stable_d <= osc_stable;
  end
  wire ev_stable = osc_stable && !osc_stable_d;

  // ---------------------------------------------------------------
  // Wake and alarm (backup domain)
  // ---------------------------------------------------------------
  logic wake_prev;
  always_ff @(posedge core_clk) begin
    if (bk_reset) begin                                // see R2
      wake_prev     <= 1'b0;
      wake_rise     <= 1'b1;
      alarm_wake_en <= 1'b0;
    end else begin
      wake_prev <= wake_s;
      if (wr_wake) begin
        wake_rise     <= bus_req.wdata[0];
        alarm_wake_en <= bus_req.wdata[1];
      end
    end
  end
  wire wake_edge = wake_rise ? (wake_s && !wake_prev) : (!wake_s && wake_prev);
  wire ev_wake   = wake_edge;
  wire ev_alarm  = alarm_s && alarm_wake_en;

  // ---------------------------------------------------------------
  // Operating mode
  // ---------------------------------------------------------------
  wire [2:0] wr_mode_val = bus_req.wdata[2:0];
  wire       wake_any    = ev_wake || ev_alarm;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode <= PCM_SLOW;                                // see R8
    end else begin
      unique case (mode)
        PCM_IDLE:       if (irq_in_s) mode <= PCM_NORMAL;       // see R10
        PCM_STANDBY:    if (irq_in_s) mode <= PCM_SLOW;         // see R12
        PCM_POWER_DOWN: if (wake_any) mode <= PCM_SLOW;         // see R13
        PCM_NORMAL, PCM_SLOW: begin
          if (wr_mode) begin
            unique case (wr_mode_val)
              // Normal needs no oscillator; the oscillator can only start outside slow mode
              3'h0:    mode <= PCM_NORMAL;                      // see R9
              3'h1:    if (main_ok) mode <= PCM_IDLE;
              3'h3:    mode <= PCM_STANDBY;
              3'h4:    mode <= PCM_POWER_DOWN;
              default: mode <= PCM_SLOW;
            endcase
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Peripheral enables, interrupt status and mask
  // ---------------------------------------------------------------
  wire [NUM_EVENTS-1:0] events = {ev_alarm, ev_wake, ev_stable};
  always_ff @(posedge core_clk) begin
    if (reset) begin
      periph_en  <= '0;
      int_mask   <= '0;
    end else begin
      if (wr_per)  periph_en <= bus_req.wdata[NUM_PERIPH-1:0];
      if (wr_mask) int_mask  <= bus_req.wdata[NUM_EVENTS-1:0];
    end
  end
  // Set wins over a write-one clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_stat
      always_ff @(posedge core_clk) begin
        if (reset) int_status[gi] <= 1'b0;
        else if (events[gi]) int_status[gi] <= 1'b1;   // see R6
        else if (wr_stat && bus_req.wdata[gi]) int_status[gi] <= 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Master clock selection and prescaler
  // ---------------------------------------------------------------
  wire main_src  = osc_bypass ? ext_clk_s : xtal_s;   // see R7
  wire sel_main  = (clk_sel != SEL_SLOW) && main_ok;
  wire src_level = sel_main ? main_src : slow_div[9];
  logic       src_prev;
  logic [6:0] pre_cnt;
  logic       mclk;
  wire        src_rise = src_level && !src_prev;
  wire [6:0]  pre_last = 7'(1) << prescale;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_prev <= 1'b0;
      pre_cnt  <= '0;
      mclk     <= 1'b0;
    end else begin
      src_prev <= src_level;
      if (src_rise) begin                              // see R15
        if (prescale == 3'h0) begin
          mclk <= ~mclk;
        end else if (pre_cnt >= (pre_last - 7'h01)) begin
          pre_cnt <= '0;
          mclk    <= ~mclk;
        end else begin
          pre_cnt <= pre_cnt + 7'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs and read back
  // ---------------------------------------------------------------
  wire core_run   = (mode == PCM_NORMAL) || (mode == PCM_SLOW);   // see R16
  wire pwr_on     = (mode != PCM_POWER_DOWN);
  wire [31:0] rd_cg = {8'h00, osc_count_cfg, 5'h00, prescale, 2'h0, clk_sel,
                       1'b0, clkout_dis, osc_bypass, osc_enable};
  wire [31:0] rd_st = {20'h0, bk_reset, pwr_on, core_run, osc_stable,
                       5'h00, int_status};
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus_req.read) begin
      unique case (bus_req.addr)
        ADDR_CLOCK_GEN: next_rdata = rd_cg;
        ADDR_MODE:      next_rdata = {29'h0, mode};
        ADDR_PERIPH_EN: next_rdata = {16'h0, periph_en};
        ADDR_STATUS:    next_rdata = rd_st;
        ADDR_INT_MASK:  next_rdata = {29'h0, int_mask};
        ADDR_WAKE_CFG:  next_rdata = {30'h0, alarm_wake_en, wake_rise};
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_rdata            <= '0;
      irq                  <= 1'b0;
      master_clock         <= 1'b0;
      master_clock_out_pin <= 1'b0;
      master_clock_out_oe  <= 1'b0;
      gates                <= '{core_clk_en: 1'b1, periph_clk_en: '0, main_osc_on: 1'b0,
                                pll_on: 1'b0, main_power_on: 1'b1};
    end else begin
      bus_rdata            <= next_rdata;
      irq                  <= |(int_status & int_mask);
      master_clock         <= mclk;
      master_clock_out_pin <= mclk;                    // see R15
      master_clock_out_oe  <= !clkout_dis;
      gates.core_clk_en    <= core_run;                // see R10
      gates.periph_clk_en  <= pwr_on ? periph_en : '0; // see R9
      gates.main_osc_on    <= osc_enable;
      gates.pll_on         <= 1'b0;                    // see R11
      gates.main_power_on  <= pwr_on;                  // see R13
    end
  end

endmodule : pcm_top

// [src/pcm_pkg.sv]
// Package for the power and clock manager: register map, fields, modes, timing.
// Assumes a single core_clk domain with a slow-clock tick produced inside the block.
package pcm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CORE_CLK_HZ      = 25000000;
  localparam int          SLOW_CLK_HZ      = 32768;
  localparam int          SLOW_DIV_CYCLES  = (CORE_CLK_HZ + SLOW_CLK_HZ / 2) / SLOW_CLK_HZ;
  localparam int          BACKUP_HOLD_SLOW = 32768;
  localparam int          OSC_DEC_PERIOD   = 8;
  localparam logic [9:0]  SLOW_DIV_LAST    = 10'(SLOW_DIV_CYCLES - 1);
  localparam logic [2:0]  OSC_DEC_LAST     = 3'(OSC_DEC_PERIOD - 1);

  // ---------------------------------------------------------------
  // Register offsets (own choice)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CLOCK_GEN   = 8'h00;
  localparam logic [7:0]  ADDR_MODE        = 8'h04;
  localparam logic [7:0]  ADDR_PERIPH_EN   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS      = 8'h0C;
  localparam logic [7:0]  ADDR_INT_MASK    = 8'h10;
  localparam logic [7:0]  ADDR_WAKE_CFG    = 8'h14;

  // Clock gen fields
  localparam int          CG_ENABLE_BIT    = 0;
  localparam int          CG_BYPASS_BIT    = 1;
  localparam int          CG_CLKOUT_DIS    = 2;
  localparam int          CG_SEL_LSB       = 4;
  localparam int          CG_PRE_LSB       = 8;
  localparam int          CG_COUNT_LSB     = 16;

  // Status / interrupt bits
  localparam int          ST_OSC_STABLE    = 0;
  localparam int          ST_WAKE          = 1;
  localparam int          ST_ALARM         = 2;
  localparam int          ST_LIVE_STABLE   = 8;
  localparam int          ST_LIVE_CORE     = 9;
  localparam int          ST_LIVE_MAIN_PWR = 10;
  localparam int          ST_LIVE_BK_RST   = 11;
  localparam int          NUM_EVENTS       = 3;

  localparam int          NUM_PERIPH       = 16;
  localparam logic [7:0]  OSC_COUNT_RESET  = 8'h00;

  // Clock source select
  localparam logic [1:0]  SEL_SLOW         = 2'h0;
  localparam logic [1:0]  SEL_MAIN         = 2'h1;

  typedef enum logic [2:0] {
    PCM_NORMAL, PCM_IDLE, PCM_SLOW, PCM_STANDBY, PCM_POWER_DOWN
  } pcm_mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } pcm_bus_req_t;

  typedef struct packed {
    logic                  core_clk_en;
    logic [NUM_PERIPH-1:0] periph_clk_en;
    logic                  main_osc_on;
    logic                  pll_on;
    logic                  main_power_on;
  } pcm_gate_t;

endpackage : pcm_pkg

// [dv/pcm_ext_model.sv]
// Parts beside the power and clock manager: crystal, external clock, backup RC.
// Assumes the testbench feeds the oscillator gate back in as osc_run.
`timescale 1ns/100ps
module pcm_ext_model #(
  parameter int RC_NS = 2000
) (
  input  wire logic osc_run,
  output logic      crystal_clk,
  output logic      main_osc_input_pin,
  output logic      backup_reset_pin
);
  // ---------------------------------------------------------------
  // Sources
  // ---------------------------------------------------------------
  // Crystal stands still while the oscillator is switched off
  initial begin
    crystal_clk = 1'b0;
    forever #31 crystal_clk = osc_run ? !crystal_clk : 1'b0;
  end
  // Free-running external clock for the bypass path
  initial begin
    main_osc_input_pin = 1'b0;
    forever #23 main_osc_input_pin = !main_osc_input_pin;
  end
  // RC network: low at power-on, high once charged
  initial begin
    backup_reset_pin = 1'b0;
    #RC_NS backup_reset_pin = 1'b1;
  end
endmodule : pcm_ext_model

// [dv/pcm_assertions.sv]
// Checker: port-level timing relations of pcm_top.
// Assumes it is bound onto pcm_top; one clock domain, core_clk.
`timescale 1ns/100ps
module pcm_checker
  import pcm_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire pcm_pkg::pcm_bus_req_t bus_req,
  input wire logic                  wake_pin,
  input wire logic                  irq_pending,
  input wire logic                  master_clock_out_pin,
  input wire logic                  master_clock_out_oe,
  input wire logic                  master_clock,
  input wire pcm_pkg::pcm_gate_t    gates
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire cg_wr = bus_req.write && bus_req.addr == ADDR_CLOCK_GEN;
  wire pe_wr = bus_req.write && bus_req.addr == ADDR_PERIPH_EN;
  wire sb_wr = bus_req.write && bus_req.addr == ADDR_MODE && bus_req.wdata[2:0] == 3'h3;
  a_reset_gates: assert property (
    $past(reset) |-> gates.core_clk_en && !gates.main_osc_on && gates.periph_clk_en == '0)
    else $error("gates wrong after reset");
  a_pll_off: assert property (!gates.pll_on)
    else $error("pll switched on");
  a_osc_stop: assert property (
    cg_wr && !bus_req.wdata[CG_ENABLE_BIT] |-> ##[1:2] !gates.main_osc_on)
    else $error("oscillator kept running");
  a_clkout_pin: assert property (master_clock_out_pin == master_clock)
    else $error("clock pin differs");
  a_oe_follow: assert property (
    $changed(master_clock_out_oe) |-> $past(cg_wr) || $past(cg_wr, 2) || $past(reset, 2))
    else $error("output enable moved alone");
  a_wake_power: assert property (
    !gates.main_power_on && $rose(wake_pin) |-> ##[1:6] gates.main_power_on)
    else $error("no power-up on wake");
  a_core_resume: assert property (
    gates.main_power_on && !gates.core_clk_en && irq_pending |-> ##[1:6] gates.core_clk_en)
    else $error("core not resumed");
  a_core_stop: assert property (
    sb_wr && gates.core_clk_en && gates.main_power_on && !irq_pending
      |-> ##[1:3] !gates.core_clk_en)
    else $error("core kept running");
  a_periph_write: assert property (
    $changed(gates.periph_clk_en) && gates.main_power_on && $past(gates.main_power_on)
      |-> $past(pe_wr) || $past(pe_wr, 2))
    else $error("peripheral gate moved alone");
endmodule : pcm_checker

// [dv/tb.sv]
// Testbench of pcm_top: register tasks, mode, clock and interrupt scenarios.
// Assumes pcm_pkg is compiled first and the external model stands beside it.
`timescale 1ns/100ps
module tb;
  import pcm_pkg::*;
  logic          core_clk;
  logic          reset;
  pcm_bus_req_t  bus_req;
  logic [31:0]   bus_rdata;
  logic          backup_reset_pin;
  logic          main_osc_input_pin;
  logic          crystal_clk;
  logic          wake_pin;
  logic          rtc_alarm;
  logic          irq_pending;
  logic          master_clock_out_pin;
  logic          master_clock_out_oe;
  logic          master_clock;
  pcm_gate_t     gates;
  logic          irq;
  int            fails;
  int            num_checks;
  logic [2:0]    mode_try [5] = '{3'h6, 3'h1, 3'h2, 3'h5, 3'h7};

  pcm_top #(.BACKUP_HOLD(4)) dut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .backup_reset_pin(backup_reset_pin),
    .main_osc_input_pin(main_osc_input_pin), .crystal_clk(crystal_clk),
    .wake_pin(wake_pin), .rtc_alarm(rtc_alarm), .irq_pending(irq_pending),
    .master_clock_out_pin(master_clock_out_pin), .master_clock_out_oe(master_clock_out_oe),
    .master_clock(master_clock), .gates(gates), .irq(irq));
  pcm_ext_model ext (.osc_run(gates.main_osc_on), .crystal_clk(crystal_clk),
    .main_osc_input_pin(main_osc_input_pin), .backup_reset_pin(backup_reset_pin));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
    d = bus_rdata;
  endtask : rd
  // Cycles between the last two master clock toggles
  task automatic gap(output int n);
    logic m;
    repeat (3) begin
      m = master_clock;
      n = 0;
      while (master_clock === m && n < 4000) begin
        @(posedge core_clk);
        #1 n++;
      end
    end
  endtask : gap
  function automatic logic [31:0] st_exp(input logic [2:0] ev, input logic bk);
    return 32'h600 | (32'(bk) << ST_LIVE_BK_RST) | 32'(ev);
  endfunction : st_exp
  task automatic complete_run;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = !core_clk;
  end
  initial begin
    #(30000 * 40);
    fails++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] v;
    int n;
    reset = 1'b1;
    bus_req = '0;
    wake_pin = 1'b0;
    rtc_alarm = 1'b0;
    irq_pending = 1'b0;
    fails = 0;
    num_checks = 0;
    void'($urandom(95827));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(ADDR_MODE, d);
    chk(d, 32'h2);
    rd(ADDR_CLOCK_GEN, d);
    chk(d & 32'h1, 32'h0);
    rd(ADDR_STATUS, d);
    chk(d & 32'hF07, st_exp(3'h0, 1'b1));
    for (n = 0; n < 200 && backup_reset_pin !== 1'b1; n++) @(posedge core_clk);
    repeat (2100) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk(d & 32'hF07, st_exp(3'h0, 1'b1));
    repeat (1100) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk(d & 32'hF07, st_exp(3'h0, 1'b0));
    rd(ADDR_WAKE_CFG, d);
    chk(d, 32'h1);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CLOCK_GEN, (32'(p) << CG_PRE_LSB) | (32'(p) << CG_CLKOUT_DIS));
      gap(n);
      chk(32'(n), 32'(SLOW_DIV_CYCLES << p));
      chk(32'(master_clock_out_oe), 32'(p == 0));
    end
    wr(ADDR_CLOCK_GEN, 32'h0003_0001);
    repeat (3) @(posedge core_clk);
    chk(32'(gates.main_osc_on), 32'h0);
    foreach (mode_try[i]) begin
      wr(ADDR_MODE, 32'(mode_try[i]));
      rd(ADDR_MODE, d);
      chk(d, 32'h2);
    end
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 32'hFFFF : (k == 1) ? 32'h0 : $urandom & 32'hFFFF;
      wr(ADDR_PERIPH_EN, v);
      rd(ADDR_PERIPH_EN, d);
      chk(d, v);
      chk(32'(gates.periph_clk_en), v);
    end
    wr(ADDR_MODE, 32'h3);
    repeat (3) @(posedge core_clk);
    chk(32'(gates.core_clk_en), 32'h0);
    chk(32'(gates.periph_clk_en), v);
    irq_pending <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(32'(gates.core_clk_en), 32'h1);
    irq_pending <= 1'b0;
    rd(ADDR_MODE, d);
    chk(d, 32'h2);
    wr(ADDR_INT_MASK, 32'h2);
    wr(ADDR_MODE, 32'h4);
    repeat (20) @(posedge core_clk);
    chk(32'(gates.main_power_on), 32'h0);
    wake_pin <= 1'b1;
    for (n = 0; n < 20 && irq !== 1'b1; n++) @(posedge core_clk);
    #1 chk(32'(irq), 32'h1);
    chk(32'(gates.main_power_on), 32'h1);
    rd(ADDR_STATUS, d);
    chk(d & 32'hF07, st_exp(3'h2, 1'b0));
    wr(ADDR_STATUS, 32'h2);
    wake_pin <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    wr(ADDR_WAKE_CFG, 32'h3);
    wr(ADDR_MODE, 32'h4);
    rtc_alarm <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(32'(gates.main_power_on), 32'h1);
    chk(32'(irq), 32'h0);
    rtc_alarm <= 1'b0;
    wr(ADDR_INT_MASK, 32'h6);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h4);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_INT_MASK, 32'h1);
    wr(ADDR_CLOCK_GEN, 32'h0000_0001);
    rd(ADDR_MODE, d);
    chk(d, 32'h0);
    chk(32'(gates.main_osc_on), 32'h1);
    repeat (5300) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk(d & 32'h101, 32'h0);
    repeat (900) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk(d & 32'hF07, st_exp(3'h1, 1'b0) | 32'h100);
    chk(32'(irq), 32'h1);
    wr(ADDR_CLOCK_GEN, 32'h0);
    repeat (2) @(posedge core_clk);
    rd(ADDR_STATUS, d);
    chk(d & 32'h101, 32'h1);
    chk(32'(gates.main_osc_on), 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, d);
    chk(d, 32'h0);
    complete_run();
  end
endmodule : tb

bind pcm_top pcm_checker u_chk (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
  .wake_pin(wake_pin), .irq_pending(irq_pending),
  .master_clock_out_pin(master_clock_out_pin), .master_clock_out_oe(master_clock_out_oe),
  .master_clock(master_clock), .gates(gates));
